// file: include/ccrd_pkg.sv
package ccrd_pkg;

	// core complex clock select codes
	localparam logic [3:0] CORE_SEL_FIRST_DIV1  = 4'h0;
	localparam logic [3:0] CORE_SEL_FIRST_DIV2  = 4'h1;
	localparam logic [3:0] CORE_SEL_SECOND_DIV1 = 4'h4;
	localparam logic [3:0] CORE_SEL_SECOND_DIV2 = 4'h5;

	// decoded core clock source
	typedef enum logic [1:0] {
		CCRD_SRC_FIRST  = 2'h0,
		CCRD_SRC_SECOND = 2'h1
	} ccrd_src_type;

	// memory ratio codes
	localparam logic [4:0] MEM_RAT_5   = 5'h05;
	localparam logic [4:0] MEM_RAT_6   = 5'h06;
	localparam logic [4:0] MEM_RAT_8   = 5'h08;
	localparam logic [4:0] MEM_RAT_9   = 5'h09;
	localparam logic [4:0] MEM_RAT_10  = 5'h0a;
	localparam logic [4:0] MEM_RAT_12  = 5'h0c;
	localparam logic [4:0] MEM_RAT_13  = 5'h0d;
	localparam logic [4:0] MEM_RAT_16  = 5'h10;
	localparam logic [4:0] MEM_RAT_18  = 5'h12;
	localparam logic [4:0] MEM_RAT_19  = 5'h13;
	localparam logic [4:0] MEM_RAT_20  = 5'h14;
	localparam logic [4:0] MEM_RAT_SYNC = 5'h01;

	// serdes bank ratio codes
	localparam logic [2:0] SRD_RAT_20 = 3'h1;
	localparam logic [2:0] SRD_RAT_25 = 3'h2;
	localparam logic [2:0] SRD_RAT_40 = 3'h3;
	localparam logic [2:0] SRD_RAT_50 = 3'h4;
	localparam logic [2:0] SRD_RAT_24 = 3'h5;
	localparam logic [2:0] SRD_RAT_30 = 3'h6;

	// decoded multiplier widths, reset values and block counts
	localparam int          MULT_W        = 6;
	localparam logic [5:0]  MULT_NONE     = 6'h00;
	localparam logic [3:0]  CORE_SEL_RST  = 4'h0;
	localparam logic [4:0]  MEM_RAT_RST   = 5'h00;
	localparam logic [2:0]  SRD_RAT_RST   = 3'h0;
	localparam int          CORE_COUNT    = 4;
	localparam int          LANE_PAIRS    = 5;
	localparam int          SRD_BANKS     = 3;

	// decoded serdes bank ratio, zero when reserved
	function automatic logic [5:0] srd_mult(input logic [2:0] code,
		input int bank);
		logic [5:0] m;
		m = MULT_NONE;
		unique case (code)
			SRD_RAT_25: m = 6'h19;
			SRD_RAT_40: m = 6'h28;
			SRD_RAT_50: m = 6'h32;
			SRD_RAT_20: m = (bank >= 2) ? 6'h14 : MULT_NONE;
			SRD_RAT_24: m = (bank == 3) ? 6'h18 : MULT_NONE;
			SRD_RAT_30: m = (bank == 3) ? 6'h1e : MULT_NONE;
			default:    m = MULT_NONE;
		endcase
		return m;
	endfunction

endpackage

// file: core/ccrd_core_select.sv
`timescale 1ns/10ps
module ccrd_core_select
	import ccrd_pkg::*;
#(
	parameter bit UPPER_PAIR = 1'b0
) (
	// select code
	input  wire logic [3:0]   selCode,
	// decoded clock
	output ccrd_src_type      srcSel,
	output logic              divTwo,
	output logic              selValid
);

	wire isFirst1  = (selCode == CORE_SEL_FIRST_DIV1);
	wire isFirst2  = !UPPER_PAIR && (selCode == CORE_SEL_FIRST_DIV2);
	wire isSecond1 = (selCode == CORE_SEL_SECOND_DIV1);
	wire isSecond2 = UPPER_PAIR && (selCode == CORE_SEL_SECOND_DIV2);

	assign selValid = isFirst1 | isFirst2 | isSecond1 | isSecond2;
	assign srcSel   = (isSecond1 | isSecond2) ? CCRD_SRC_SECOND
	                                          : CCRD_SRC_FIRST;
	assign divTwo   = isFirst2 | isSecond2;

endmodule // ccrd_core_select

// file: core/ccrd_clock_ratio_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - complexes 0 and 1 take 0000 first/1, 0001 first/2, 0100 second/1.
// - complexes 2 and 3 take 0000 first/1, 0100 second/1, 0101 second/2.
// - memory pll reference is system clock when async, platform when sync.
// - async memory ratio accepts only the eleven listed codes.
// - sync memory ratio accepts only code 0_0001, a 1:1 ratio.
// - serdes ratio decode per bank, 001 banks 2-3, 101/110 bank 3 only.
// - each bank 1 divider bit picks divide by 1 or 2.
// - bank 1 divider bits map in order to lane pairs 0/1 up to 8/9.
// - one divider bit per bank 2 and 3 covers all four lanes.
module ccrd_clock_ratio_decoder
	import ccrd_pkg::*;
(
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// configuration word fields
	input  wire logic [15:0]           coreSelWord,
	input  wire logic                  memSyncBit,
	input  wire logic                  memRateBit,
	input  wire logic                  memReservedBit,
	input  wire logic [4:0]            memPllRatio,
	input  wire logic [1:0]            memPllRange,
	input  wire logic [8:0]            serdesRatioWord,
	input  wire logic [4:0]            serdesBank1Div,
	input  wire logic [1:0]            serdesBankDiv,
	// decoded core clocks
	output ccrd_src_type [3:0]         coreSrc,
	output logic [3:0]                 coreDivTwo,
	// decoded memory clock
	output logic                       memRefPlatform,
	output logic [4:0]                 memRatio,
	output logic                       memRangeHigh,
	// decoded serdes clocks
	output logic [17:0]                serdesMult,
	output logic [4:0]                 lanePairDivTwo,
	output logic [1:0]                 bankDivTwo,
	// status
	output logic                       configDone,
	output logic                       configError
);

	////////////////////////////////////////////////////////////////////////
	// combinational decode of the live fields

	ccrd_src_type [3:0] srcLive;
	logic [3:0]         divLive;
	logic [3:0]         coreOk;
	logic [17:0]        srdLive;
	logic [2:0]         srdOk;

	genvar gi;
	generate
		for (gi = 0; gi < CORE_COUNT; gi++) begin : g_core
			ccrd_core_select #(.UPPER_PAIR(gi >= 2)) u_sel (
				.selCode  (coreSelWord[gi*4 +: 4]),
				.srcSel   (srcLive[gi]),
				.divTwo   (divLive[gi]),
				.selValid (coreOk[gi])
			);
		end
		for (gi = 0; gi < SRD_BANKS; gi++) begin : g_srd
			assign srdLive[gi*MULT_W +: MULT_W] =
				srd_mult(serdesRatioWord[gi*3 +: 3], gi + 1);
			assign srdOk[gi] = (srdLive[gi*MULT_W +: MULT_W] != MULT_NONE);
		end
	endgenerate

	wire asyncOk = (memPllRatio == MEM_RAT_5)  || (memPllRatio == MEM_RAT_6)
	            || (memPllRatio == MEM_RAT_8)  || (memPllRatio == MEM_RAT_9)
	            || (memPllRatio == MEM_RAT_10) || (memPllRatio == MEM_RAT_12)
	            || (memPllRatio == MEM_RAT_13) || (memPllRatio == MEM_RAT_16)
	            || (memPllRatio == MEM_RAT_18) || (memPllRatio == MEM_RAT_19)
	            || (memPllRatio == MEM_RAT_20);
	wire syncOk  = (memPllRatio == MEM_RAT_SYNC);
	// the two mode bits must agree and the reserved bit must be clear
	wire modeOk  = (memSyncBit == memRateBit) && !memReservedBit;
	wire memOk   = modeOk && (memSyncBit ? syncOk : asyncOk);

	////////////////////////////////////////////////////////////////////////
	// one-shot capture after reset release

	logic armed_reg;
	logic capture;
	assign capture = !sys_rst && !armed_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			armed_reg <= 1'b0;
		else
			armed_reg <= 1'b1;
	end

	ccrd_src_type [3:0] coreSrc_reg;
	logic [3:0]         coreDiv_reg;
	logic               memPlat_reg;
	logic [4:0]         memRat_reg;
	logic               memRange_reg;
	logic [17:0]        srdMult_reg;
	logic [4:0]         laneDiv_reg;
	logic [1:0]         bankDiv_reg;
	logic               err_reg;

	generate
		for (gi = 0; gi < CORE_COUNT; gi++) begin : g_core_hold
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					coreSrc_reg[gi] <= CCRD_SRC_FIRST;
					coreDiv_reg[gi] <= 1'b0;
				end else if (capture && coreOk[gi]) begin
					coreSrc_reg[gi] <= srcLive[gi];
					coreDiv_reg[gi] <= divLive[gi];
				end
			end
		end
		for (gi = 0; gi < SRD_BANKS; gi++) begin : g_srd_hold
			always_ff @(posedge core_clk) begin
				if (sys_rst)
					srdMult_reg[gi*MULT_W +: MULT_W] <= MULT_NONE;
				else if (capture && srdOk[gi])
					srdMult_reg[gi*MULT_W +: MULT_W] <=
						srdLive[gi*MULT_W +: MULT_W];
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			memPlat_reg  <= 1'b0;
			memRat_reg   <= MEM_RAT_RST;
			memRange_reg <= 1'b0;
		end else if (capture && memOk) begin
			memPlat_reg  <= memSyncBit;
			memRat_reg   <= memPllRatio;
			memRange_reg <= memPllRange[0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			laneDiv_reg <= '0;
			bankDiv_reg <= '0;
			err_reg     <= 1'b0;
		end else if (capture) begin
			laneDiv_reg <= serdesBank1Div;
			bankDiv_reg <= serdesBankDiv;
			err_reg     <= !(&coreOk) || !memOk || !(&srdOk);
		end
	end

	assign coreSrc        = coreSrc_reg;
	assign coreDivTwo     = coreDiv_reg;
	assign memRefPlatform = memPlat_reg;
	assign memRatio       = memRat_reg;
	assign memRangeHigh   = memRange_reg;
	assign serdesMult     = srdMult_reg;
	assign lanePairDivTwo = laneDiv_reg;
	assign bankDivTwo     = bankDiv_reg;
	assign configDone     = armed_reg;
	assign configError    = err_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_capture;
		capture;
	endsequence

	a_hold_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
		configDone |=> $stable(memRatio) && $stable(coreDivTwo))
		else $error("decoded selections changed after capture");

	a_error_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture ##0 !memOk |=> configError)
		else $error("reserved memory code not flagged");

	a_mem_unchanged: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture ##0 !memOk |=> memRatio == $past(memRatio))
		else $error("reserved memory code altered the ratio");

	a_mem_ref: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture ##0 memOk |=> memRefPlatform == $past(memSyncBit))
		else $error("memory reference source wrong");

	a_sync_ratio: assert property (@(posedge core_clk) disable iff (sys_rst)
		configDone && memRefPlatform |-> memRatio == MEM_RAT_SYNC)
		else $error("sync mode with unsupported ratio");

	a_core_div: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture ##0 coreSelWord[3:0] == CORE_SEL_FIRST_DIV2
		|=> coreDivTwo[0] && coreSrc[0] == CCRD_SRC_FIRST)
		else $error("complex 0 first/2 not decoded");

	a_core_upper: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture ##0 coreSelWord[15:12] == CORE_SEL_SECOND_DIV2
		|=> coreDivTwo[3] && coreSrc[3] == CCRD_SRC_SECOND)
		else $error("complex 3 second/2 not decoded");

	a_bank1_ratio: assert property (@(posedge core_clk) disable iff (sys_rst)
		configDone |-> serdesMult[5:0] != 6'd20)
		else $error("bank 1 accepted the 20:1 code");

	a_lane_div: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture |=> lanePairDivTwo == $past(serdesBank1Div)
		&& bankDivTwo == $past(serdesBankDiv))
		else $error("divider bits not captured");

	a_srd_refused: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture ##0 !srdOk[0] |=> serdesMult[5:0] == MULT_NONE)
		else $error("reserved serdes code altered bank 1");

	a_done_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_capture |=> configDone && !$past(configDone))
		else $error("done flag did not rise at capture");

endmodule // ccrd_clock_ratio_decoder

// file: tb/ccrd_config_source.sv
`timescale 1ns/10ps
module ccrd_config_source #(
	// board link setup, values arbitrary
	parameter int PLAT_MHZ     = 600,
	parameter int PEX_LANE_MHZ = 100,
	parameter int PEX_W0       = 4,
	parameter int PEX_W1       = 2,
	parameter int PEX_W2       = 1,
	parameter int PEX_W3       = 1,
	parameter int SRIO_MHZ     = 2500,
	parameter int SRIO_WIDTH   = 4
) (
	// requested setup
	input  wire logic       syncMode,
	input  wire logic [4:0] ratioCode,
	input  wire logic       refAbove,
	input  wire logic       breakMode,
	// configuration word fields
	output logic            memSyncBit,
	output logic            memRateBit,
	output logic            memReservedBit,
	output logic [4:0]      memPllRatio,
	output logic [1:0]      memPllRange,
	// platform clock meets the link floors
	output logic            linkFloorOk
);
	// widest single trained port, never the sum of all ports
	localparam int PEX_MAX_LO = (PEX_W0 > PEX_W1) ? PEX_W0 : PEX_W1;
	localparam int PEX_MAX_HI = (PEX_W2 > PEX_W3) ? PEX_W2 : PEX_W3;
	localparam int PEX_WIDEST = (PEX_MAX_LO > PEX_MAX_HI) ? PEX_MAX_LO
	                                                      : PEX_MAX_HI;
	// 2 * 0.8512 * f * w / 64 against platform, scaled by 10000
	localparam int SRIO_NEED  = 2 * 8512 * SRIO_MHZ * SRIO_WIDTH;
	localparam int SRIO_HAVE  = PLAT_MHZ * 64 * 10000;
	assign linkFloorOk = (PLAT_MHZ >= PEX_LANE_MHZ * PEX_WIDEST)
	                  && (SRIO_HAVE >= SRIO_NEED);
	// rate bit only disagrees when a scenario asks for a broken word
	assign memSyncBit     = syncMode;
	assign memRateBit     = syncMode ^ breakMode;
	assign memReservedBit = 1'b0;
	assign memPllRatio    = ratioCode;
	// refAbove: reference sits above the cutoff of the chosen ratio
	assign memPllRange    = {1'b0, refAbove};
endmodule // ccrd_config_source

// file: tb/ccrd_clock_ratio_decoder_test.sv
`timescale 1ns/10ps
module ccrd_clock_ratio_decoder_test
	import ccrd_pkg::*;
;
	typedef struct packed {
		logic [15:0] core;
		logic        sync;
		logic [4:0]  ratio;
		logic        hi;
		logic [8:0]  srd;
		logic [4:0]  b1;
		logic [1:0]  bd;
		logic [7:0]  src;
		logic [3:0]  div;
		logic [4:0]  mratio;
		logic        mref;
		logic [17:0] mult;
		logic        err;
	} ccrd_row_type;

	logic core_clk, sys_rst, syncMode, refAbove, breakMode;
	logic memSyncBit, memRateBit, memReservedBit, memRangeHigh;
	logic memRefPlatform, configDone, configError, linkFloorOk;
	logic [15:0] coreSelWord;
	logic [4:0] ratioCode, memPllRatio, serdesBank1Div, memRatio;
	logic [4:0] lanePairDivTwo;
	logic [1:0] memPllRange, serdesBankDiv, bankDivTwo;
	logic [8:0] serdesRatioWord;
	logic [17:0] serdesMult;
	logic [3:0] coreDivTwo;
	ccrd_src_type [3:0] coreSrc;
	int failures, total_checks;
	ccrd_row_type rows [4] = '{
	'{16'h5410,1'b0,5'h05,1'b1,9'h18a,5'h15,2'h2,8'h50,4'ha,5'h05,1'b0,
		{6'd30,6'd20,6'd25},1'b0},
	'{16'h0404,1'b1,5'h01,1'b0,9'h163,5'h0a,2'h1,8'h11,4'h0,5'h01,1'b1,
		{6'd24,6'd50,6'd40},1'b0},
	'{16'h0100,1'b0,5'h14,1'b1,9'h119,5'h00,2'h3,8'h00,4'h0,5'h14,1'b0,
		{6'd50,6'd40,6'd0},1'b1},
	'{16'h4000,1'b1,5'h05,1'b0,9'h1e8,5'h1f,2'h0,8'h40,4'h0,5'h00,1'b0,
		18'h0,1'b1}};
	logic [4:0] legal [11] = '{5'h05,5'h06,5'h08,5'h09,5'h0a,5'h0c,5'h0d,
		5'h10,5'h12,5'h13,5'h14};

	ccrd_config_source src (.syncMode(syncMode), .ratioCode(ratioCode),
		.refAbove(refAbove), .breakMode(breakMode), .memSyncBit(memSyncBit),
		.memRateBit(memRateBit), .memReservedBit(memReservedBit),
		.memPllRatio(memPllRatio), .memPllRange(memPllRange),
		.linkFloorOk(linkFloorOk));
	ccrd_clock_ratio_decoder dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.coreSelWord(coreSelWord), .memSyncBit(memSyncBit),
		.memRateBit(memRateBit), .memReservedBit(memReservedBit),
		.memPllRatio(memPllRatio), .memPllRange(memPllRange),
		.serdesRatioWord(serdesRatioWord), .serdesBank1Div(serdesBank1Div),
		.serdesBankDiv(serdesBankDiv), .coreSrc(coreSrc),
		.coreDivTwo(coreDivTwo), .memRefPlatform(memRefPlatform),
		.memRatio(memRatio), .memRangeHigh(memRangeHigh),
		.serdesMult(serdesMult), .lanePairDivTwo(lanePairDivTwo),
		.bankDivTwo(bankDivTwo), .configDone(configDone),
		.configError(configError));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check_vec(input logic [17:0] got, exp, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic close_out();
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one reset pulse then the capture edge
	task automatic capture(input ccrd_row_type r);
		@(posedge core_clk);
		#1 sys_rst = 1'b1;
		{coreSelWord, syncMode, ratioCode, refAbove} = {r.core, r.sync,
			r.ratio, r.hi};
		{serdesRatioWord, serdesBank1Div, serdesBankDiv} = {r.srd, r.b1, r.bd};
		@(posedge core_clk);
		#1 sys_rst = 1'b0;
		@(posedge core_clk);
		#1;
	endtask

	initial begin
		#100us;
		failures++;
		close_out();
	end

	initial begin
		sys_rst = 1'b1;
		{syncMode, refAbove, breakMode, ratioCode, coreSelWord} = '0;
		{serdesRatioWord, serdesBank1Div, serdesBankDiv} = '0;
		repeat (8) @(posedge core_clk);
		#1;
		check_vec({configDone, configError, memRatio}, 0, "rst");
		check_vec(serdesMult, 0, "rst mult");
		check_vec(linkFloorOk, 1'b1, "floor");
		foreach (rows[i]) begin
			capture(rows[i]);
			check_vec(18'(coreSrc), rows[i].src, "src");
			check_vec(coreDivTwo, rows[i].div, "div");
			check_vec(memRatio, rows[i].mratio, "ratio");
			check_vec(memRefPlatform, rows[i].mref, "ref");
			check_vec(memRangeHigh, rows[i].hi, "range");
			check_vec(serdesMult, rows[i].mult, "mult");
			check_vec(lanePairDivTwo, rows[i].b1, "pair");
			check_vec(bankDivTwo, rows[i].bd, "bank");
			check_vec({configDone, configError}, {1'b1, rows[i].err}, "st");
		end
		foreach (legal[i]) begin
			capture('{core: 16'h5401, sync: 0, ratio: legal[i],
				srd: 9'h092, default: 0});
			check_vec({configError, memRatio}, {1'b0, legal[i]}, "async");
		end
		// async code 01 and mode mismatch are both refused
		for (int k = 0; k < 2; k++) begin
			breakMode = k[0];
			capture('{core: 0, sync: k[0], ratio: 5'h01, srd: 9'h092, default: 0});
			check_vec({configError, memRefPlatform, memRatio}, 7'h40, "bad");
		end
		breakMode = 1'b0;
		capture(rows[0]);
		coreSelWord = 16'h1111;
		ratioCode = 5'h14;
		serdesRatioWord = 9'h000;
		repeat (3) @(posedge core_clk);
		#1;
		check_vec({memRatio, serdesMult[5:0], coreDivTwo}, {5'h05, 6'd25, 4'ha},
			"hold");
		check_vec({configDone, configError}, 2'h2, "hold st");
		close_out();
	end
endmodule // ccrd_clock_ratio_decoder_test
